// *** hw/eeprom_program_erase_control.sv ***
// Purpose: Program/erase sequencing, protection and timebase for a 512-byte array on Wishbone
// Assumes: Classic Wishbone, 32-bit data, byte data in lane 0; array modelled in flops
// Notes:   Nonvolatile bytes are not reset; they start erased at power-up

`timescale 1ns/1ns

// Contract
// (RL1) Tick from selectable clock, 16-bit divider; the ratio uses only 15 bits, with the top bit of the high byte as security
// (RL2) Divider source picked by select input
// (RL3) Software loads divider before any operation
// (RL4) Armed security blocks secured sixteen bytes
// (RL5) Secured bytes still read normally
// (RL6) Armed security freezes nonvolatile configuration
// (RL7) Armed: no block/bulk erase; byte ops allowed
// (RL8) Four 128-byte blocks, one protect bit each
// (RL9) Protect loads at reset or config read
// (RL10) Divider security locks divider registers permanently
// (RL11) Erased bits read one, delivered as ff
// (RL12) Program clears bits only, one byte max
// (RL13) Erase sets bits, byte up to array
// (RL14) Software never reprograms a zero bit
// (RL15) Auto mode ends cycle, clears enable
// (RL16) Software follows latch, write, enable sequence
// (RL17) Latch captures valid writes; control gated
// (RL18) Later writes overwrite; reads return latched
// (RL19) Enable refused without latch or valid address
// (RL20) Software avoids array reads during enable
// (RL21) Clearing both clears only program enable
// (RL22) Only unprotected bytes and config programmable
// (RL23) Mode encoding; protect bit forbids everything
// (RL24) Latch held while program enable set
// (RL25) Reset copies nonvolatile into volatile registers
// (RL26) Divider ticks time the automatic cycle
module eeprom_program_erase_control
    import eeprom_pkg::*;
#(
    parameter int AUTO_TICK_COUNT = AUTO_TICKS,
    parameter int RATIO_W = 15
) (
    input wire logic ref_clk, // Bus clock, 250 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [12:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic oscillator_reference_clock, // Reference clock pin
    input wire logic divider_clock_select, // Option strap for divider source
    output logic charge_pump_on // High voltage applied
);
    import eeprom_pkg::*;

    // ======================================================================
    // Storage
    logic [7:0] mem [ARRAY_BYTES];
    logic [7:0] nv_array_config;
    logic [7:0] nv_divider_high;
    logic [7:0] nv_divider_low;

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] cfg_r;
    logic [7:0] div_high_r;
    logic [7:0] div_low_r;
    logic load_r;
    logic [10:0] lat_adr_r;
    logic [7:0] lat_dat_r;
    logic lat_valid_r;
    op_mode_t op_mode_r;
    logic op_auto_r;
    logic spoiled_r;
    logic [15:0] ticks_r;
    logic ack_r;
    logic [31:0] dat_r;

    // ======================================================================
    // Decode
    logic req;
    logic wr;
    logic rd;
    logic [10:0] idx;
    logic hit_array;
    logic hit_nv;
    logic valid_target;
    logic [7:0] wdata;
    logic [7:0] rd_byte;
    logic tick;

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd = req & ~wb_we_i;
    assign idx = wb_adr_i[12:2];
    assign wdata = wb_dat_i[7:0];

    function automatic logic in_array(input logic [10:0] a);
        in_array = (a >= ARRAY_FIRST) && (a <= ARRAY_LAST);
    endfunction : in_array

    function automatic logic is_nv(input logic [10:0] a);
        is_nv = (a == IDX_NVCFG) || (a == IDX_NVDIVH) || (a == IDX_NVDIVL);
    endfunction : is_nv

    assign hit_array = in_array(idx);
    assign hit_nv = is_nv(idx);
    assign valid_target = hit_array | hit_nv;

    // ======================================================================
    // Protection
    logic armed;
    logic div_locked;
    logic [3:0] block_protect;

    // Either copy being zero arms it; the nonvolatile bit makes it permanent
    assign armed = ~nv_array_config[CFG_SECURITY] | ~cfg_r[CFG_SECURITY];           // RL4
    assign div_locked = ~div_high_r[DIV_SECURITY];                                  // RL10
    assign block_protect = cfg_r[3:0];                                              // RL8

    function automatic logic op_allowed(input logic [10:0] a, input op_mode_t m,
                                        input logic [3:0] bp, input logic arm, input logic dlock);
        logic [1:0] blk;
        blk = a[8:7];
        if (in_array(a)) begin
            if (m != OP_BULK_ERASE && bp[blk]) begin
                op_allowed = 1'b0; // RL23
            end else if (arm && ((a >= SECURE_FIRST && a <= SECURE_LAST) || m[1])) begin
                op_allowed = 1'b0; // RL7
            end else begin
                op_allowed = 1'b1;
            end
        end else if (a == IDX_NVCFG) begin
            op_allowed = !arm && !m[1]; // RL6
        end else if (a == IDX_NVDIVH || a == IDX_NVDIVL) begin
            op_allowed = !dlock && !m[1]; // RL10
        end else begin
            op_allowed = 1'b0; // RL22
        end
    endfunction : op_allowed

    function automatic logic [7:0] apply_op(input logic [7:0] old, input logic [7:0] d, input op_mode_t m);
        apply_op = (m == OP_BYTE_PROGRAM) ? (old & d) : ERASED_BYTE;                // RL12 RL13
    endfunction : apply_op

    // ======================================================================
    // Control sequencing
    logic pgm_r;
    logic latch_r;
    logic ctrl_wr;
    logic ctrl_accept;
    logic pgm_set_ok;
    logic start;
    logic auto_done;
    logic sw_end;
    logic commit;
    logic commit_ok;
    logic valid_target_latched;

    assign pgm_r = ctrl_r[CTRL_PGM];
    assign latch_r = ctrl_r[CTRL_LATCH];
    assign ctrl_wr = wr && idx == IDX_CTRL;
    assign valid_target_latched = in_array(lat_adr_r) | is_nv(lat_adr_r);
    assign ctrl_accept = ctrl_wr && (!latch_r || lat_valid_r); // RL17
    assign pgm_set_ok = latch_r && lat_valid_r && valid_target_latched; // RL19

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_accept) begin
            ctrl_nxt = wdata & CTRL_RW_MASK;
            ctrl_nxt[CTRL_PGM] = wdata[CTRL_PGM] && (pgm_r || pgm_set_ok);          // RL19
            ctrl_nxt[CTRL_LATCH] = wdata[CTRL_LATCH] || pgm_r;                      // RL21 RL24
        end
        if (auto_done) begin
            ctrl_nxt[CTRL_PGM] = 1'b0;                                              // RL15
        end
    end

    assign start = !pgm_r && ctrl_nxt[CTRL_PGM];
    assign auto_done = pgm_r && op_auto_r && tick && (ticks_r + 16'd1 >= 16'(AUTO_TICK_COUNT)); // RL15 RL26
    assign sw_end = pgm_r && ctrl_accept && !wdata[CTRL_PGM] && !op_auto_r;
    assign commit = auto_done | sw_end;
    assign commit_ok = commit && !spoiled_r && op_allowed(lat_adr_r, op_mode_r, block_protect, armed, div_locked);
    assign charge_pump_on = pgm_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RESET;
            op_mode_r <= OP_BYTE_PROGRAM;
            op_auto_r <= 1'b0;
            ticks_r <= '0;
            spoiled_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (start) begin
                op_mode_r <= op_mode_t'(ctrl_nxt[CTRL_OP_HI:CTRL_OP_LO]);           // RL23
                op_auto_r <= ctrl_nxt[CTRL_AUTO];
                ticks_r <= '0;
                spoiled_r <= 1'b0;
            end else if (pgm_r && tick) begin
                ticks_r <= ticks_r + 16'd1; // RL26
            end
            // Array read under high voltage ruins the cycle
            if (pgm_r && rd && hit_array) begin
                spoiled_r <= 1'b1; // RL20
            end
        end
    end

    // ======================================================================
    // Address and data latch
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lat_adr_r <= '0;
            lat_dat_r <= ERASED_BYTE;
            lat_valid_r <= 1'b0;
        end else if (!latch_r) begin
            lat_valid_r <= 1'b0;
        end else if (!pgm_r) begin
            if (wr && valid_target) begin
                lat_adr_r <= idx;                                                   // RL17 RL18
                lat_dat_r <= wdata;
                lat_valid_r <= 1'b1;
            end else if (rd && hit_array) begin
                lat_adr_r <= idx;                                                   // RL18
                lat_valid_r <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Volatile configuration and divider
    logic cfg_read;
    assign cfg_read = rd && idx == IDX_NVCFG;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_r <= 1'b1;
            cfg_r <= CFG_RESET;
            div_high_r <= DIV_RESET;
            div_low_r <= DIV_RESET;
        end else begin
            load_r <= 1'b0;
            if (load_r) begin
                cfg_r <= nv_array_config;                                           // RL25
                div_high_r <= nv_divider_high;
                div_low_r <= nv_divider_low;
            end else begin
                if (cfg_read) begin
                    cfg_r <= nv_array_config;                                       // RL9
                end else if (wr && idx == IDX_CFG) begin
                    cfg_r <= (cfg_r & ~CFG_RW_MASK) | (wdata & CFG_RW_MASK);
                end
                // Security flag itself only follows the nonvolatile copy
                if (wr && idx == IDX_DIVH && !div_locked) begin
                    div_high_r <= {div_high_r[DIV_SECURITY], wdata[6:0]};           // RL10
                end
                if (wr && idx == IDX_DIVL && !div_locked) begin
                    div_low_r <= wdata;                                             // RL10
                end
            end
        end
    end

    eeprom_timebase #(
        .RATIO_W(RATIO_W)
    ) u_timebase (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .oscillator_reference_clock(oscillator_reference_clock),
        .divider_clock_select(divider_clock_select),
        .ratio({div_high_r[6:0], div_low_r}),                                       // RL1
        .tick(tick)
    );

    // ======================================================================
    // Nonvolatile cells: no reset, erased at power-up
    initial begin
        for (int i = 0; i < ARRAY_BYTES; i++) begin
            mem[i] = ERASED_BYTE; // RL11
        end
        nv_array_config = ERASED_BYTE;
        nv_divider_high = ERASED_BYTE;
        nv_divider_low = ERASED_BYTE;
    end

    always @(posedge ref_clk) begin
        if (commit_ok) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                if (in_array(lat_adr_r) &&
                    ((op_mode_r[1] == 1'b0 && 9'(i) == lat_adr_r[8:0]) ||
                     (op_mode_r == OP_BLOCK_ERASE && 2'(i >> 7) == lat_adr_r[8:7]) ||
                     (op_mode_r == OP_BULK_ERASE && !block_protect[2'(i >> 7)]))) begin
                    mem[i] <= apply_op(mem[i], lat_dat_r, op_mode_r);               // RL22
                end
            end
            if (lat_adr_r == IDX_NVCFG) begin
                nv_array_config <= apply_op(nv_array_config, lat_dat_r, op_mode_r);
            end
            if (lat_adr_r == IDX_NVDIVH) begin
                nv_divider_high <= apply_op(nv_divider_high, lat_dat_r, op_mode_r);
            end
            if (lat_adr_r == IDX_NVDIVL) begin
                nv_divider_low <= apply_op(nv_divider_low, lat_dat_r, op_mode_r);
            end
        end
    end

    // ======================================================================
    // Bus answer: one wait state, unmapped reads return zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            IDX_CTRL: rd_byte = ctrl_r;
            IDX_CFG: rd_byte = cfg_r;
            IDX_NVCFG: rd_byte = nv_array_config;
            IDX_DIVH: rd_byte = div_high_r;
            IDX_DIVL: rd_byte = div_low_r;
            IDX_NVDIVH: rd_byte = nv_divider_high;
            IDX_NVDIVL: rd_byte = nv_divider_low;
            default: begin
                if (hit_array) begin
                    rd_byte = latch_r ? lat_dat_r : mem[idx[8:0]];                  // RL5 RL18
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (rd) begin
                dat_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule : eeprom_program_erase_control

// *** hw/eeprom_timebase.sv ***
// Purpose: Shared constants and the timebase divider for the array program/erase controller
// Assumes: One bus clock; the oscillator reference arrives as an asynchronous pin level
// Notes:   Ticks are one-cycle enables on the bus clock, never a derived clock

`timescale 1ns/1ns

// ==========================================================================
// Package
package eeprom_pkg;
    // Word indexes on the bus; byte address is four times the index
    localparam logic [10:0] IDX_CTRL = 11'h000;
    localparam logic [10:0] IDX_CFG = 11'h001;
    localparam logic [10:0] IDX_NVCFG = 11'h002;
    localparam logic [10:0] IDX_DIVH = 11'h003;
    localparam logic [10:0] IDX_DIVL = 11'h004;
    localparam logic [10:0] IDX_NVDIVH = 11'h005;
    localparam logic [10:0] IDX_NVDIVL = 11'h006;
    localparam logic [10:0] ARRAY_FIRST = 11'h600;
    localparam logic [10:0] ARRAY_LAST = 11'h7ff;
    localparam logic [10:0] SECURE_FIRST = 11'h6f0;
    localparam logic [10:0] SECURE_LAST = 11'h6ff;
    localparam int ARRAY_BYTES = 512;

    // array_control fields
    localparam int CTRL_PGM = 0;
    localparam int CTRL_AUTO = 2;
    localparam int CTRL_LATCH = 3;
    localparam int CTRL_OP_LO = 4;
    localparam int CTRL_OP_HI = 5;
    localparam logic [7:0] CTRL_RW_MASK = 8'hfd;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Array configuration fields
    localparam int CFG_SECURITY = 4;
    localparam logic [7:0] CFG_RW_MASK = 8'he0;
    localparam logic [7:0] CFG_RESET = 8'hff;
    // Divider high byte: security flag on top, ratio bits below
    localparam int DIV_SECURITY = 7;
    localparam logic [7:0] DIV_RESET = 8'hff;

    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Timebase and automatic termination
    localparam int TICK_TIME_US = 35;
    localparam int AUTO_TIME_US = 8750;
    localparam int AUTO_TICKS = AUTO_TIME_US / TICK_TIME_US;

    typedef enum logic [1:0] {
        OP_BYTE_PROGRAM = 2'b00,
        OP_BYTE_ERASE = 2'b01,
        OP_BLOCK_ERASE = 2'b10,
        OP_BULK_ERASE = 2'b11
    } op_mode_t;
endpackage : eeprom_pkg

// ==========================================================================
// Timebase divider
module eeprom_timebase #(
    parameter int RATIO_W = 15
) (
    input wire logic ref_clk, // Bus clock
    input wire logic reset_n, // Async reset, active low
    input wire logic oscillator_reference_clock, // Asynchronous reference pin
    input wire logic divider_clock_select, // 1 oscillator, 0 bus clock
    input wire logic [RATIO_W-1:0] ratio, // Reference cycles per tick
    output logic tick // One-cycle timebase pulse
);
    logic osc_meta_r;
    logic osc_sync_r;
    logic osc_prev_r;
    logic [RATIO_W-1:0] count_r;
    logic src_en;
    logic wrap;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_meta_r <= oscillator_reference_clock;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    // Zero ratio behaves as one so the tick never stalls
    assign src_en = divider_clock_select ? (osc_sync_r & ~osc_prev_r) : 1'b1; // RL2
    assign wrap = src_en && (count_r + 1'b1 >= ratio);                        // RL1

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= wrap;                                                     // RL26
            if (wrap) begin
                count_r <= '0;
            end else if (src_en) begin
                count_r <= count_r + 1'b1;
            end
        end
    end
endmodule : eeprom_timebase

// *** testbench/cpu_bus_master.sv ***
// Purpose: CPU stand-in, Wishbone classic master
// Assumes: Ack and data taken at the rising edge
// Notes:   Released address and data lines carry junk, not old values
`timescale 1ns/1ns
// ====
// Master
module cpu_bus_master (
    input wire logic ref_clk, // Clock
    input wire logic wb_ack_o, // Ack
    input wire logic [31:0] wb_dat_o, // Read data
    output logic wb_cyc_i, // Cycle
    output logic wb_stb_i, // Strobe
    output logic wb_we_i, // Write
    output logic [12:0] wb_adr_i, // Address
    output logic [3:0] wb_sel_i, // Lanes
    output logic [31:0] wb_dat_i // Write data
);
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 13'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end
    task automatic x(input logic w, input logic [10:0] i, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {i, 2'($urandom)};
        wb_sel_i <= {3'($urandom), 1'b1};
        wb_dat_i <= {24'($urandom), d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_adr_i <= ~wb_adr_i;
        wb_dat_i <= ~wb_dat_i;
    endtask : x
endmodule : cpu_bus_master

// *** testbench/pec_props.sv ***
// Purpose: Port checks for the program/erase controller
// Assumes: One clock domain
// Notes:   Bound to the top module
`timescale 1ns/1ns
// ====
// Checker
module pec_props
    import eeprom_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [12:0] wb_adr_i, // Address
    input wire logic [3:0] wb_sel_i, // Lanes
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic charge_pump_on // Pump
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    wire take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [10:0] idx_w = wb_adr_i[12:2];
    wire ctrl_rd_w = take_w && !wb_we_i && idx_w == IDX_CTRL;
    wire pgm_wr_w = take_w && wb_we_i && wb_sel_i[0] && wb_dat_i[CTRL_PGM] && idx_w == IDX_CTRL;
    sequence s_ctrl_read;
        ctrl_rd_w ##1 wb_ack_o;
    endsequence
    a_ack_next: assert property (take_w |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ack_asked: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper set");
    a_unmapped_zero: assert property (take_w && !wb_we_i && idx_w > IDX_NVDIVL && idx_w < ARRAY_FIRST
        |=> wb_dat_o == 32'h0) else $error("unmapped data");
    a_ctrl_mirror: assert property (s_ctrl_read |-> wb_dat_o[CTRL_PGM] == $past(charge_pump_on))
        else $error("pump mismatch");
    a_latch_held: assert property ((ctrl_rd_w && charge_pump_on) ##1 wb_ack_o |-> wb_dat_o[CTRL_LATCH])
        else $error("latch dropped");
    a_pump_cause: assert property ($rose(charge_pump_on) |-> $past(pgm_wr_w) || $past(pgm_wr_w, 2))
        else $error("pump unasked");
endmodule : pec_props
bind eeprom_program_erase_control pec_props u_pec_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .charge_pump_on(charge_pump_on)
);

// *** testbench/tb_eeprom_program_erase_control.sv ***
// Purpose: Self-checking bench for the program/erase controller
// Assumes: Short auto count, divider ratio 2
// Notes:   Array and nv bytes mirrored in the bench
`timescale 1ns/1ns
// ====
// Bench
module tb_eeprom_program_erase_control;
    import eeprom_pkg::*;
    localparam int NT = 3;
    localparam int RT = 2;
    logic clk = 1'b0, rst_n = 1'b0, osc = 1'b0, src = 1'b0;
    logic cyc, stb, we, ack, pump;
    logic [12:0] adr;
    logic [3:0] sel;
    logic [31:0] di, dq;
    logic [7:0] mem [0:511];
    logic [7:0] nv [0:6];
    logic [7:0] cfg_m, q;
    logic dlock_m;
    int error_cnt = 0, checks = 0, cyc_n = 0, plen = 0, last_len = 0, od = 0;
    eeprom_program_erase_control #(.AUTO_TICK_COUNT(NT), .RATIO_W(15)) u_eeprom_program_erase_control (
        .ref_clk(clk), .reset_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack), .oscillator_reference_clock(osc),
        .divider_clock_select(src), .charge_pump_on(pump));
    cpu_bus_master u_cpu_bus_master (.ref_clk(clk), .wb_ack_o(ack), .wb_dat_o(dq), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        od <= (od == 2) ? 0 : od + 1;
        if (od == 2) osc <= ~osc;
        if (cyc_n == 40000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end
    // Pump length seen at settled points
    always @(negedge clk) begin
        if (!pump && plen != 0) last_len = plen;
        plen = pump ? plen + 1 : 0;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic wr(input logic [10:0] i, input logic [7:0] d);
        u_cpu_bus_master.x(1'b1, i, d, q);
    endtask : wr
    task automatic rc(input logic [10:0] i, input logic [7:0] e);
        u_cpu_bus_master.x(1'b0, i, 8'h00, q);
        chk(q, e);
    endtask : rc
    function automatic logic armed();
        armed = !nv[IDX_NVCFG][CFG_SECURITY] || !cfg_m[CFG_SECURITY];
    endfunction : armed
    function automatic logic hit(int i, logic [10:0] a, logic [1:0] m);
        int t;
        t = int'(a - ARRAY_FIRST);
        hit = (m[1] ? (m[0] || i / 128 == t / 128) : i == t) && !cfg_m[i / 128]
            && !(armed() && (m[1] || (i >= 240 && i < 256)));
    endfunction : hit
    // Enable, end the cycle, drop the latch, then mirror the result
    task automatic fin(input logic [1:0] m, input logic au, input logic [10:0] a, input logic [7:0] d);
        logic [7:0] c;
        int p;
        c = {2'b00, m, 1'b1, au, 2'b00};
        p = src ? 6 : 1;
        wr(IDX_CTRL, c | 8'h01);
        if (au) begin
            do u_cpu_bus_master.x(1'b0, IDX_CTRL, 8'h00, q); while (q[CTRL_PGM] !== 1'b0);
            chk(q, c);
            chk_rng(last_len, (NT - 1) * RT * p, NT * RT * p + 8);
        end else begin
            rc(IDX_CTRL, c | 8'h01);
            wr(IDX_CTRL, {2'b00, m, 4'h0});
            rc(IDX_CTRL, c);
        end
        wr(IDX_CTRL, 8'h00);
        if (a >= ARRAY_FIRST) begin
            for (int i = 0; i < ARRAY_BYTES; i++) if (hit(i, a, m)) mem[i] = m == 2'b00 ? mem[i] & d : ERASED_BYTE;
        end else if (!m[1] && ((a == IDX_NVCFG && !armed()) || (a >= IDX_NVDIVH && !dlock_m))) begin
            nv[a] = m[0] ? ERASED_BYTE : nv[a] & d;
        end
    endtask : fin
    task automatic op(input logic [1:0] m, input logic au, input logic [10:0] a, input logic [7:0] d);
        wr(IDX_CTRL, {2'b00, m, 1'b1, au, 2'b00});
        wr(a, d);
        fin(m, au, a, d);
    endtask : op
    task automatic chk_all();
        for (int i = 0; i < ARRAY_BYTES; i++) rc(ARRAY_FIRST + 11'(i), mem[i]);
    endtask : chk_all
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cfg_m = nv[IDX_NVCFG];
        dlock_m = !nv[IDX_NVDIVH][DIV_SECURITY];
    endtask : do_reset
    task automatic tally_and_finish();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        logic [10:0] a;
        void'($urandom(20055));
        for (int i = 0; i < ARRAY_BYTES; i++) mem[i] = ERASED_BYTE;
        for (int i = 0; i < 7; i++) nv[i] = ERASED_BYTE;
        do_reset();
        rc(IDX_CTRL, CTRL_RESET);
        rc(IDX_CFG, 8'hff);
        rc(ARRAY_FIRST + 11'($urandom_range(511)), ERASED_BYTE);
        rc(11'h123, 8'h00);
        wr(IDX_CTRL, 8'h01);
        rc(IDX_CTRL, 8'h00);
        wr(IDX_CTRL, 8'h08);
        wr(IDX_CTRL, 8'h09);
        rc(IDX_CTRL, 8'h08);
        wr(11'h640, 8'h11);
        wr(11'h650, 8'h22);
        rc(11'h660, 8'h22);
        fin(2'b00, 1'b0, 11'h660, 8'h22);
        rc(11'h650, mem[80]);
        $display("latch test done");
        wr(IDX_DIVH, 8'h00);
        wr(IDX_DIVL, 8'(RT));
        rc(IDX_DIVL, 8'(RT));
        op(2'b00, 1'b0, IDX_NVCFG, 8'hf8);
        rc(IDX_CFG, 8'hff);
        rc(IDX_NVCFG, 8'hf8);
        cfg_m = 8'hf8;
        rc(IDX_CFG, 8'hf8);
        for (int k = 0; k < 8; k++) begin
            a = ARRAY_FIRST + 11'(k * 48 + $urandom_range(47));
            src <= k[0];
            op(2'b00, 1'b1, a, ~(8'($urandom) & mem[a - ARRAY_FIRST]));
            op(2'b00, 1'b1, a, ~(8'($urandom) & mem[a - ARRAY_FIRST]));
            rc(a, mem[a - ARRAY_FIRST]);
        end
        src <= 1'b0;
        op(2'b01, 1'b0, a, 8'h00);
        op(2'b00, 1'b1, 11'h7a0, 8'h0f);
        $display("program test done");
        op(2'b00, 1'b1, 11'h790, 8'h00);
        op(2'b10, 1'b1, 11'h605, 8'h00);
        chk_all();
        op(2'b11, 1'b0, 11'h700, 8'h00);
        chk_all();
        $display("protect test done");
        op(2'b00, 1'b0, 11'h6f5, 8'h5a);
        op(2'b00, 1'b0, 11'h610, 8'h0f);
        op(2'b00, 1'b0, IDX_NVCFG, 8'hef);
        rc(IDX_NVCFG, 8'he8);
        cfg_m = 8'he8;
        op(2'b00, 1'b1, 11'h6f5, 8'ha5);
        op(2'b01, 1'b1, 11'h6f6, 8'h00);
        op(2'b10, 1'b0, 11'h610, 8'h00);
        op(2'b11, 1'b1, 11'h610, 8'h00);
        op(2'b01, 1'b1, 11'h610, 8'h00);
        chk_all();
        op(2'b01, 1'b0, IDX_NVCFG, 8'h00);
        rc(IDX_NVCFG, 8'he8);
        $display("security test done");
        op(2'b00, 1'b0, IDX_NVDIVH, 8'h00);
        op(2'b00, 1'b0, IDX_NVDIVL, 8'(RT));
        do_reset();
        rc(IDX_DIVH, 8'h00);
        rc(IDX_DIVL, 8'(RT));
        rc(IDX_CFG, 8'he8);
        wr(IDX_DIVL, 8'h05);
        rc(IDX_DIVL, 8'(RT));
        op(2'b01, 1'b0, IDX_NVDIVL, 8'h00);
        rc(IDX_NVDIVL, 8'(RT));
        $display("divider lock test done");
        tally_and_finish();
    end
endmodule : tb_eeprom_program_erase_control
